// ### design/bas_params.svh
`ifndef BAS_PARAMS_SVH
`define BAS_PARAMS_SVH
// apb register offsets
`define BAS_OFS_CFG_ZERO 12'h000
`define BAS_OFS_CFG_ONE 12'h004
`define BAS_OFS_STATUS 12'h008
`define BAS_OFS_CUR_ADDR 12'h00c
// cfg_reg_zero fields and reset
`define BAS_CFG_ZERO_RST 16'h8f2f
`define BAS_HYB_BIT 2
`define BAS_BLEN_HI 1
`define BAS_BLEN_LO 0
// cfg_reg_one fields and reset; bits 1:0 read only
`define BAS_CFG_ONE_RST 16'hffc1
`define BAS_CFG_ONE_RO_MASK 16'h0003
`define BAS_BTYPE_BIT 7
// burst length codes
`define BAS_BLEN_128 2'h0
`define BAS_BLEN_64 2'h1
`define BAS_BLEN_16 2'h2
`define BAS_BLEN_32 2'h3
// group sizes in bytes, step between data words
`define BAS_GRP_128 8'h80
`define BAS_GRP_64 8'h40
`define BAS_GRP_16 8'h10
`define BAS_GRP_32 8'h20
`define BAS_WORD_STEP 32'h0000_0002
`endif

// ### design/bas_pkg.sv
package bas_pkg;
  typedef enum logic [1:0]
  {
    BAS_IDLE = 2'h0,
    BAS_RUN = 2'h1,
    BAS_DRAIN = 2'h3
  } bas_state_e;
  typedef logic [31:0] bas_addr_t;
endpackage

// ### design/bas_push_if.sv
interface bas_push_if;
  logic valid;
  logic ready;
  bas_pkg::bas_addr_t data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// ### design/bas_skid_buf.sv
// two-entry buffer between the sequencer and the address consumer
module bas_skid_buf (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  bas_push_if.dst in_port,
  output logic out_valid,
  output bas_pkg::bas_addr_t out_data,
  input wire logic out_ready
);
  bas_pkg::bas_addr_t spare_reg;
  logic [1:0] count_reg;
  // ----------------------------------------
  // handshake decode
  // ----------------------------------------
  wire push = in_port.valid & in_port.ready;
  wire pop = out_valid & out_ready;
  // ready from count only, so no loop through out_ready
  assign in_port.ready = (count_reg != 2'h2);

  // head and spare slots
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= 2'h0;
      out_valid <= 1'b0;
      out_data <= 32'h0000_0000;
      spare_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (push && !pop)
        count_reg <= count_reg + 2'h1;
      else if (pop && !push)
        count_reg <= count_reg - 2'h1;
      if (count_reg == 2'h0)
      begin
        if (push)
        begin
          out_data <= in_port.data;
          out_valid <= 1'b1;
        end
      end
      else if (count_reg == 2'h1)
      begin
        if (pop && push)
          out_data <= in_port.data;
        else if (push)
          spare_reg <= in_port.data;
        else if (pop)
          out_valid <= 1'b0;
      end
      else if (pop)
        out_data <= spare_reg; // spare moves up
    end
  end
endmodule

// ### design/bas_top.sv
`include "bas_params.svh"
// Summary of operation
// [RULE_01] wrap group is 16/32/64/128 bytes, aligned
// [RULE_02] wrapped burst stays inside the command's group
// [RULE_03] start address upward, wrap to group start
// [RULE_04] host keeps wrapped bursts off die boundary
// [RULE_05] hybrid first does one full ordinary wrap
// [RULE_06] hybrid then runs linear from next group
// [RULE_07] host keeps hybrid bursts off die boundary
// [RULE_08] hybrid bit zero hybrid, one legacy; reset one
// [RULE_09] legacy wrap keeps cycling until chip select high
// [RULE_10] linear burst increments without wrapping
// [RULE_11] length code 00=128 01=64 10=16 11=32
// [RULE_12] hybrid bit ignored unless command type bit zero
// [RULE_13] cfg one bit seven: one linear, zero wrapped; code still runs linear on zero when cmd_linear is set
module bas_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cs_n_pin,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_addr,
  input wire logic cmd_linear,
  output logic addr_valid,
  output logic [31:0] addr_data,
  input wire logic addr_ready
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [15:0] cfg_zero_reg;
  logic [15:0] cfg_one_reg;
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic cs_high_reg;
  bas_pkg::bas_state_e state_reg;
  bas_pkg::bas_state_e state_next;
  bas_pkg::bas_addr_t addr_reg;
  bas_pkg::bas_addr_t addr_next;
  bas_pkg::bas_addr_t start_reg;
  logic [7:0] grp_reg;
  logic [6:0] words_reg;
  logic linear_reg;
  logic hybrid_reg;
  logic [7:0] grp_dec;
  bas_push_if push_if ();

  // ----------------------------------------
  // apb slave, one wait state per access
  // ----------------------------------------
  wire acc = psel & penable & ~pready;
  wire hit_zero = (paddr == `BAS_OFS_CFG_ZERO);
  wire hit_one = (paddr == `BAS_OFS_CFG_ONE);
  wire hit_stat = (paddr == `BAS_OFS_STATUS);
  wire hit_cur = (paddr == `BAS_OFS_CUR_ADDR);
  wire hit_any = hit_zero | hit_one | hit_stat | hit_cur;
  wire busy = (state_reg != bas_pkg::BAS_IDLE);
  // read-only bits of cfg one survive writes
  wire [15:0] one_wr = (pwdata[15:0] & ~`BAS_CFG_ONE_RO_MASK)
    | (cfg_one_reg & `BAS_CFG_ONE_RO_MASK);
  wire [31:0] rd_mux = hit_zero ? {16'h0000, cfg_zero_reg}
    : hit_one ? {16'h0000, cfg_one_reg}
    : hit_stat ? {30'h0000_0000, cs_high_reg, busy}
    : hit_cur ? addr_reg : 32'h0000_0000;

  // register access completes at the pready edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      cfg_zero_reg <= `BAS_CFG_ZERO_RST; // RULE_08
      cfg_one_reg <= `BAS_CFG_ONE_RST; // RULE_13
    end
    else if (ce)
    begin
      pready <= acc;
      pslverr <= acc & ~hit_any;
      prdata <= acc & ~pwrite ? rd_mux : 32'h0000_0000;
      if (psel && penable && pready && pwrite && hit_zero)
        cfg_zero_reg <= pwdata[15:0];
      if (psel && penable && pready && pwrite && hit_one)
        cfg_one_reg <= one_wr;
    end
  end

  // ----------------------------------------
  // chip select synchroniser and filter
  // ----------------------------------------
  // a change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      cs_high_reg <= 1'b1;
    end
    else if (ce)
    begin
      cs_s1_reg <= cs_n_pin;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      if (cs_s2_reg == cs_s3_reg)
        cs_high_reg <= cs_s3_reg;
    end
  end

  // ----------------------------------------
  // burst mode and group decode
  // ----------------------------------------
  wire [1:0] blen = cfg_zero_reg[`BAS_BLEN_HI:`BAS_BLEN_LO];
  always_comb
  begin
    case (blen) // RULE_11
      `BAS_BLEN_128: grp_dec = `BAS_GRP_128;
      `BAS_BLEN_64: grp_dec = `BAS_GRP_64;
      `BAS_BLEN_16: grp_dec = `BAS_GRP_16;
      default: grp_dec = `BAS_GRP_32; // RULE_01
    endcase
  end
  // linear if either the command or cfg one asks for it
  wire start_linear = cmd_linear | cfg_one_reg[`BAS_BTYPE_BIT]; // RULE_13
  // hybrid bit only matters for a wrapped command
  wire start_hybrid = ~start_linear & ~cfg_zero_reg[`BAS_HYB_BIT]; // RULE_12
  wire start = (state_reg == bas_pkg::BAS_IDLE) & cmd_valid & ~cs_high_reg;

  // ----------------------------------------
  // next address
  // ----------------------------------------
  wire [31:0] mask = {24'h00_0000, grp_reg - 8'h01};
  wire [31:0] step = addr_reg + `BAS_WORD_STEP;
  wire [31:0] wrap_nxt = (addr_reg & ~mask) | (step & mask); // RULE_02
  wire [31:0] grp_after = (start_reg & ~mask) + {24'h00_0000, grp_reg};
  wire [6:0] grp_words = grp_reg[7:1];
  wire wrap_done = (words_reg == grp_words - 7'h01);
  wire emit = push_if.valid & push_if.ready;
  always_comb
  begin
    if (linear_reg)
      addr_next = step; // RULE_10 RULE_06
    else if (hybrid_reg && wrap_done)
      addr_next = grp_after; // RULE_05 RULE_06
    else
      addr_next = wrap_nxt; // RULE_03 RULE_09
  end

  // ----------------------------------------
  // sequencer state machine
  // ----------------------------------------
  always_comb
  begin
    case (state_reg)
      bas_pkg::BAS_IDLE:
        state_next = start ? bas_pkg::BAS_RUN : bas_pkg::BAS_IDLE;
      bas_pkg::BAS_RUN:
        state_next = cs_high_reg ? bas_pkg::BAS_DRAIN
          : bas_pkg::BAS_RUN; // RULE_09
      bas_pkg::BAS_DRAIN:
        state_next = bas_pkg::BAS_IDLE;
      default:
        state_next = bas_pkg::BAS_IDLE;
    endcase
  end
  assign push_if.valid = (state_reg == bas_pkg::BAS_RUN) & ~cs_high_reg;
  assign push_if.data = addr_reg;

  // burst registers; a stall by the consumer holds the address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= bas_pkg::BAS_IDLE;
      addr_reg <= 32'h0000_0000;
      start_reg <= 32'h0000_0000;
      grp_reg <= `BAS_GRP_32;
      words_reg <= 7'h00;
      linear_reg <= 1'b1;
      hybrid_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      if (start)
      begin
        addr_reg <= cmd_addr;
        start_reg <= cmd_addr;
        grp_reg <= grp_dec;
        words_reg <= 7'h00;
        linear_reg <= start_linear;
        hybrid_reg <= start_hybrid;
      end
      else if (emit)
      begin
        addr_reg <= addr_next;
        if (hybrid_reg && wrap_done)
        begin
          linear_reg <= 1'b1; // RULE_06
          hybrid_reg <= 1'b0;
        end
        words_reg <= wrap_done ? 7'h00 : words_reg + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  bas_skid_buf u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_port(push_if.dst),
    .out_valid(addr_valid),
    .out_data(addr_data),
    .out_ready(addr_ready)
  );
endmodule

// ### tb/bas_props.sv
// ----------------------------------------
// port checks for the burst sequencer
// ----------------------------------------
module bas_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cs_n_pin,
  input wire logic addr_valid,
  input wire logic [31:0] addr_data,
  input wire logic addr_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // bus access waiting for its answer
  sequence s_acc;
    psel && penable && !pready && ce;
  endsequence
  // chip select settled high and buffer drained
  sequence s_cs_off;
    cs_n_pin [*5] ##0 !addr_valid;
  endsequence
  property p_answer;
    s_acc |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_pulse;
    pready && ce |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pready");
  property p_idle_data;
    !pready |-> prdata == 32'h0;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("prdata");
  property p_upper;
    pready |-> prdata[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_unmapped;
    pready && paddr > 12'h00c |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("lone error");
  property p_hold;
    addr_valid && !(addr_ready && ce) |=> addr_valid && $stable(addr_data);
  endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  property p_freeze;
    !ce |=> $stable(addr_valid) && $stable(pready);
  endproperty
  a_freeze: assert property (p_freeze) else $error("ran frozen");
  property p_cs_quiet;
    s_cs_off |=> !addr_valid;
  endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("push");
endmodule
bind bas_top bas_props props_u (.*);

// ### tb/bas_sink_model.sv
// ----------------------------------------
// address consumer at the far side
// ----------------------------------------
module bas_sink_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  output logic addr_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // random stalls when slow, so the buffer fills up
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      addr_ready <= 1'b0;
    else
      addr_ready <= !slow || ($urandom_range(3) == 0);
endmodule

// ### tb/burst_address_sequencer_tb_top.sv
// ----------------------------------------
// bench for the burst sequencer
// ----------------------------------------
module burst_address_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, addr_data, cmd_addr = 0;
  logic pready, pslverr, addr_valid, addr_ready, slow = 0;
  logic cs_n_pin = 1, cmd_valid = 0, cmd_linear = 0;
  int failures = 0, comparisons = 0;
  int gs[4] = '{128, 64, 16, 32};
  always #5 pclk = ~pclk;
  bas_top dut_u (.*);
  bas_sink_model snk_u (.pclk, .presetn, .slow, .addr_ready);
  task automatic chk(input logic [31:0] a, e, input string m);
    comparisons++;
    if (a !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, a, e);
    end
  endtask
  task automatic wrap_up;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one apb transfer; request held until pready seen
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // judged on pready itself, so a late but valid answer still counts
    if (pready !== 1'b1)
    begin
      failures++;
      wrap_up();
    end
  endtask
  // expected byte address of word i; m 0 linear, 1 legacy, 2 hybrid
  function automatic logic [31:0] exp_a(logic [31:0] s, int g, m, i);
    logic [31:0] b;
    b = s & ~32'(g - 1);
    if (m == 0)
      return s + 32'(2 * i);
    if (m == 2 && i >= g / 2)
      return b + 32'(g + 2 * (i - g / 2));
    return b + ((s - b + 32'(2 * i)) % 32'(g));
  endfunction
  // one cs-low frame; ce dropped at random to freeze the block
  task automatic burst(input int m, g, input logic lc, input int n);
    logic [31:0] s;
    int k, t;
    s = $urandom_range(16'h7ffe) & 32'hfffe;
    if ($urandom_range(1))
      s = s | 32'(g - 2);
    @(posedge pclk);
    cs_n_pin <= 0;
    repeat (5) @(posedge pclk);
    cmd_valid <= 1;
    cmd_addr <= s;
    cmd_linear <= lc;
    @(posedge pclk);
    cmd_valid <= 0;
    k = 0;
    t = 0;
    while (k < n && t < 3000)
    begin
      @(posedge pclk);
      t++;
      if (addr_valid && addr_ready && ce)
      begin
        chk(addr_data, exp_a(s, g, m, k), "address");
        k++;
      end
      ce <= ($urandom_range(7) != 0);
    end
    cs_n_pin <= 1;
    ce <= 1;
    // words pushed before cs was seen high still sit in the buffer;
    // they must leave before the next frame or they pass as its first
    repeat (12) @(posedge pclk);
    while (addr_valid && t < 3000)
    begin
      @(posedge pclk);
      t++;
    end
    if (k < n || t >= 3000)
    begin
      failures++;
      wrap_up();
    end
  endtask
  initial
  begin
    logic [31:0] r;
    logic e;
    void'($urandom(32'ha39aa4e9));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0, r, e);
    chk(r, 32'h8f2f, "cfg zero reset");
    apb(0, 12'h004, 0, r, e);
    chk(r, 32'hffc1, "cfg one reset");
    chk({31'h0, e}, 32'h0, "mapped error");
    apb(0, 12'h010, 0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    burst(0, 32, 0, 20);
    // idle after the frame: busy low, filtered cs high
    apb(0, 12'h008, 0, r, e);
    chk(r, 32'h2, "status idle");
    apb(1, 12'h004, 32'hff40, r, e);
    apb(0, 12'h004, 0, r, e);
    chk(r, 32'hff41, "cfg one read only");
    for (int c = 0; c < 8; c++)
    begin
      slow <= c[0];
      apb(1, 12'h000, 32'h8f28 | 32'(c), r, e);
      burst(c[2] ? 1 : 2, gs[c % 4], 0, gs[c % 4] / 2 + 6);
    end
    apb(1, 12'h000, 32'h8f2a, r, e);
    apb(0, 12'h000, 0, r, e);
    chk(r, 32'h8f2a, "cfg zero readback");
    burst(0, 16, 1, 12);
    wrap_up();
  end
endmodule
